// ### display_completion_notifier.sv
// Overview of operation
// - Code 0001: show field 1 only; set first-field done and complete status.
// - Noncontinuous: first-field flag still set at next field 1 start raises not-acked.
// - Code 0001 also serves single progressive frames; clear within blanking.
// - Code 0010: show field 2 only; set second-field done and complete status.
// - Noncontinuous: second-field flag still set at next field 2 start raises not-acked.
// - Code 0011: show both fields; each field sets its flag and complete status.
// - Code 0100: both fields; picture done after field 2; not-acked at next frame end.
// - Code 0101: field 1 as frame; picture done after it; not-acked next frame end.
// - Code 0111: one frame; picture done after field 2; clear before next field 1.
// - Code 1001: repeat field 1; first-field done each time; never not-acked.
// - Code 1010: repeat field 2; second-field done each time; never not-acked.
// - Code 1100: repeat both fields; picture done after field 2; never not-acked.
// - Code 1101: like continuous field 1 but sets picture done instead.
// - Continuous modes may mask the complete interrupt while flags still set.
// - Undisplayed field issues no DMA requests, still shows default data.
// - After not-acked in noncontinuous mode, DMA requests continue for next field.
`timescale 1ns/1ps
`default_nettype none

module display_completion_notifier (
  input  wire logic REF_CLK,
  input  wire logic NRST,
  input  wire logic DISPLAY_ENABLE,
  input  wire logic CONTINUOUS_DISPLAY_SEL,
  input  wire logic PICTURE_SEL,
  input  wire logic SECOND_FIELD_SELECT,
  input  wire logic FIRST_FIELD_SELECT,
  input  wire logic COMPLETE_IRQ_ENABLE,
  input  wire logic FIELD1_START,
  input  wire logic FIELD1_END,
  input  wire logic FIELD2_START,
  input  wire logic FIELD2_END,
  input  wire logic CLEAR_FIRST_FIELD_DONE,
  input  wire logic CLEAR_SECOND_FIELD_DONE,
  input  wire logic CLEAR_PICTURE_DONE,
  input  wire logic CLEAR_COMPLETE,
  output var  logic FIRST_FIELD_DONE_FLAG,
  output var  logic SECOND_FIELD_DONE_FLAG,
  output var  logic PICTURE_DONE_FLAG,
  output var  logic DISPLAY_COMPLETE_STATUS,
  output var  logic DISPLAY_COMPLETE_IRQ,
  output var  logic COMPLETION_NOT_ACKED_IRQ,
  output var  logic DMA_REQUEST_ENABLE,
  output var  logic DATA_FROM_FIFO
);
  import display_notify_pkg::*;

  // ----------------------------------------------------------------
  // Timing strobes come from the output timing generator on this clock
  // ----------------------------------------------------------------
  logic [SEL_W-1:0] sel;
  logic             cont;
  logic             show_f1;
  logic             show_f2;
  logic             set_f1d;
  logic             set_f2d;
  logic             set_frm;
  logic             late_f1;
  logic             late_f2;
  logic             late_frm;
  logic             frame_end;
  logic             next_nack;
  logic             done_event;
  phase_t           phase;
  logic             display_on;
  logic             field_close;

  assign sel  = {CONTINUOUS_DISPLAY_SEL, PICTURE_SEL, SECOND_FIELD_SELECT, FIRST_FIELD_SELECT};
  assign cont = CONTINUOUS_DISPLAY_SEL;

  // Enable is written on the processor clock; two flops trade two cycles of lag for safety
  display_pin_sync display_pin_sync_i (.clk(REF_CLK), .nrst(NRST), .din(DISPLAY_ENABLE),
                                       .dout(display_on));

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  always_comb
  begin
    show_f1 = 1'b0;
    show_f2 = 1'b0;
    set_f1d = 1'b0;
    set_f2d = 1'b0;
    set_frm = 1'b0;
    case (sel)
      SEL_NC_F1, SEL_C_F1:
      begin
        show_f1 = 1'b1;
        set_f1d = FIELD1_END;
      end
      SEL_NC_F2, SEL_C_F2:
      begin
        show_f2 = 1'b1;
        set_f2d = FIELD2_END;
      end
      SEL_NC_BOTH:
      begin
        show_f1 = 1'b1;
        show_f2 = 1'b1;
        set_f1d = FIELD1_END;
        set_f2d = FIELD2_END;
      end
      SEL_NC_FRAME, SEL_NC_SINGLE, SEL_C_FRAME:
      begin
        show_f1 = 1'b1;
        show_f2 = 1'b1;
        set_frm = FIELD2_END;
      end
      SEL_NC_PROG, SEL_C_PROG:
      begin
        show_f1 = 1'b1;
        set_frm = FIELD1_END;
      end
      // Reserved codes display nothing and flag nothing
      default:
        show_f1 = 1'b0;
    endcase
  end

  // Frame completion point depends on which field closes the frame
  assign frame_end = (sel == SEL_NC_PROG) ? FIELD1_END : FIELD2_END;
  assign done_event = set_f1d | set_f2d | set_frm;

  // ----------------------------------------------------------------
  // Not-acknowledged detection, noncontinuous only
  // ----------------------------------------------------------------
  assign late_f1  = (sel == SEL_NC_F1 || sel == SEL_NC_BOTH) &&
                    FIELD1_START && FIRST_FIELD_DONE_FLAG;
  assign late_f2  = (sel == SEL_NC_F2 || sel == SEL_NC_BOTH) &&
                    FIELD2_START && SECOND_FIELD_DONE_FLAG;
  // Single frame mode must clear before field 1 begins again
  assign late_frm = PICTURE_DONE_FLAG &&
                    (((sel == SEL_NC_FRAME || sel == SEL_NC_PROG) && frame_end) ||
                     (sel == SEL_NC_SINGLE && FIELD1_START));
  assign next_nack = !cont && display_on && (late_f1 || late_f2 || late_frm);

  // ----------------------------------------------------------------
  // Sticky flags; a set in the clearing cycle wins
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      FIRST_FIELD_DONE_FLAG   <= FLAG_RESET;
      SECOND_FIELD_DONE_FLAG  <= FLAG_RESET;
      PICTURE_DONE_FLAG       <= FLAG_RESET;
      DISPLAY_COMPLETE_STATUS <= FLAG_RESET;
    end
    else
    begin
      FIRST_FIELD_DONE_FLAG   <= (display_on && set_f1d) ||
                                 (FIRST_FIELD_DONE_FLAG && !CLEAR_FIRST_FIELD_DONE);
      SECOND_FIELD_DONE_FLAG  <= (display_on && set_f2d) ||
                                 (SECOND_FIELD_DONE_FLAG && !CLEAR_SECOND_FIELD_DONE);
      PICTURE_DONE_FLAG       <= (display_on && set_frm) ||
                                 (PICTURE_DONE_FLAG && !CLEAR_PICTURE_DONE);
      DISPLAY_COMPLETE_STATUS <= (display_on && done_event) ||
                                 (DISPLAY_COMPLETE_STATUS && !CLEAR_COMPLETE);
    end
  end

  // ----------------------------------------------------------------
  // Interrupt pulses
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      DISPLAY_COMPLETE_IRQ     <= 1'b0;
      COMPLETION_NOT_ACKED_IRQ <= 1'b0;
    end
    else
    begin
      // Mask only gates the pulse; flags above still set
      DISPLAY_COMPLETE_IRQ     <= display_on && done_event &&
                                  (COMPLETE_IRQ_ENABLE || !cont);
      COMPLETION_NOT_ACKED_IRQ <= next_nack;
    end
  end

  // ----------------------------------------------------------------
  // Field phase and DMA gating; not-acked does not stop requests
  // ----------------------------------------------------------------
  assign field_close = (FIELD1_END && phase == PHASE_FIELD1) ||
                       (FIELD2_END && phase == PHASE_FIELD2);

  always_ff @(posedge REF_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      phase              <= PHASE_IDLE;
      DMA_REQUEST_ENABLE <= 1'b0;
      DATA_FROM_FIFO     <= 1'b0;
    end
    else
    begin
      case (phase)
        PHASE_IDLE:
        begin
          if (FIELD1_START)
            phase <= PHASE_FIELD1;
          else if (FIELD2_START)
            phase <= PHASE_FIELD2;
        end
        PHASE_FIELD1:
        begin
          if (FIELD1_END)
            phase <= PHASE_IDLE;
        end
        PHASE_FIELD2:
        begin
          if (FIELD2_END)
            phase <= PHASE_IDLE;
        end
        default:
          phase <= PHASE_IDLE;
      endcase
      DMA_REQUEST_ENABLE <= display_on &&
                            ((FIELD1_START && show_f1) || (FIELD2_START && show_f2) ||
                             (DMA_REQUEST_ENABLE && !field_close));
      DATA_FROM_FIFO     <= display_on &&
                            ((FIELD1_START && show_f1) || (FIELD2_START && show_f2) ||
                             (DATA_FROM_FIFO && !field_close));
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_f1_set;
    @(posedge REF_CLK) disable iff (!NRST)
    (display_on && FIELD1_END && (sel == SEL_NC_F1 || sel == SEL_C_F1))
      |=> FIRST_FIELD_DONE_FLAG && DISPLAY_COMPLETE_STATUS;
  endproperty
  a_f1_set: assert property (p_f1_set) else $error("first field flag missed");

  property p_f1_late;
    @(posedge REF_CLK) disable iff (!NRST)
    (display_on && FIELD1_START && FIRST_FIELD_DONE_FLAG && sel == SEL_NC_F1)
      |=> COMPLETION_NOT_ACKED_IRQ;
  endproperty
  a_f1_late: assert property (p_f1_late) else $error("field 1 not-acked missed");

  property p_f2_set;
    @(posedge REF_CLK) disable iff (!NRST)
    (display_on && FIELD2_END && sel == SEL_NC_F2)
      |=> SECOND_FIELD_DONE_FLAG && DISPLAY_COMPLETE_STATUS;
  endproperty
  a_f2_set: assert property (p_f2_set) else $error("second field flag missed");

  property p_f2_late;
    @(posedge REF_CLK) disable iff (!NRST)
    (display_on && FIELD2_START && SECOND_FIELD_DONE_FLAG && sel == SEL_NC_BOTH)
      |=> COMPLETION_NOT_ACKED_IRQ;
  endproperty
  a_f2_late: assert property (p_f2_late) else $error("field 2 not-acked missed");

  property p_frame_set;
    @(posedge REF_CLK) disable iff (!NRST)
    (display_on && FIELD2_END &&
     (sel == SEL_NC_FRAME || sel == SEL_NC_SINGLE || sel == SEL_C_FRAME))
      |=> PICTURE_DONE_FLAG && DISPLAY_COMPLETE_STATUS;
  endproperty
  a_frame_set: assert property (p_frame_set) else $error("picture flag missed");

  property p_prog_set;
    @(posedge REF_CLK) disable iff (!NRST)
    (display_on && FIELD1_END && sel == SEL_C_PROG && !FIRST_FIELD_DONE_FLAG
     && !CLEAR_PICTURE_DONE) |=> PICTURE_DONE_FLAG && !FIRST_FIELD_DONE_FLAG;
  endproperty
  a_prog_set: assert property (p_prog_set) else $error("progressive flag wrong");

  property p_cont_quiet;
    @(posedge REF_CLK) disable iff (!NRST)
    $past(CONTINUOUS_DISPLAY_SEL) |-> !COMPLETION_NOT_ACKED_IRQ;
  endproperty
  a_cont_quiet: assert property (p_cont_quiet) else $error("not-acked in continuous");

  property p_mask;
    @(posedge REF_CLK) disable iff (!NRST)
    (CONTINUOUS_DISPLAY_SEL && !COMPLETE_IRQ_ENABLE) |=> !DISPLAY_COMPLETE_IRQ;
  endproperty
  a_mask: assert property (p_mask) else $error("masked complete interrupt fired");

  property p_no_dma;
    @(posedge REF_CLK) disable iff (!NRST)
    (FIELD2_START && !FIELD1_START && sel == SEL_NC_F1 && !DMA_REQUEST_ENABLE)
      |=> !DMA_REQUEST_ENABLE;
  endproperty
  a_no_dma: assert property (p_no_dma) else $error("DMA for hidden field");

  c_nack: cover property (@(posedge REF_CLK) disable iff (!NRST) COMPLETION_NOT_ACKED_IRQ);
  c_frame: cover property (@(posedge REF_CLK) disable iff (!NRST) $rose(PICTURE_DONE_FLAG));
  c_f2: cover property (@(posedge REF_CLK) disable iff (!NRST) $rose(SECOND_FIELD_DONE_FLAG));

endmodule : display_completion_notifier
`default_nettype wire

// ### display_notify_pkg.sv
package display_notify_pkg;

  // ----------------------------------------------------------------
  // Display selection code: {continuous, picture, second, first}
  // ----------------------------------------------------------------
  localparam int          SEL_W             = 4;
  localparam logic [3:0]  SEL_NC_F1         = 4'h1;
  localparam logic [3:0]  SEL_NC_F2         = 4'h2;
  localparam logic [3:0]  SEL_NC_BOTH       = 4'h3;
  localparam logic [3:0]  SEL_NC_FRAME      = 4'h4;
  localparam logic [3:0]  SEL_NC_PROG       = 4'h5;
  localparam logic [3:0]  SEL_NC_SINGLE     = 4'h7;
  localparam logic [3:0]  SEL_C_F1          = 4'h9;
  localparam logic [3:0]  SEL_C_F2          = 4'hA;
  localparam logic [3:0]  SEL_C_FRAME       = 4'hC;
  localparam logic [3:0]  SEL_C_PROG        = 4'hD;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic        FLAG_RESET        = 1'b0;
  localparam logic        SYNC_RESET        = 1'b0;

  typedef enum logic [1:0] {
    PHASE_IDLE,
    PHASE_FIELD1,
    PHASE_FIELD2
  } phase_t;

endpackage : display_notify_pkg

// ### display_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

module display_pin_sync (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic din,
  output var  logic dout
);
  import display_notify_pkg::*;

  logic stage1;

  // Stage one feeds only stage two
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      stage1 <= SYNC_RESET;
      dout   <= SYNC_RESET;
    end
    else
    begin
      stage1 <= din;
      dout   <= stage1;
    end
  end

endmodule : display_pin_sync
`default_nettype wire

// ### display_timing_model.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Field timing and servicing software model
// ----------------------------------------------------------------
module display_timing_model (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       prompt,
  input  wire logic [3:0] flags,
  output var  logic [1:0] field_start,
  output var  logic [1:0] field_end,
  output var  logic [3:0] clr
);
  int wait_cnt;

  initial
  begin
    field_start = 2'h0;
    field_end = 2'h0;
  end

  // Caller enters just after a rising edge
  task automatic run_field(input logic [1:0] sel, input int len);
    field_start <= sel;
    @(posedge clk);
    field_start <= 2'h0;
    repeat (len) @(posedge clk);
    field_end <= sel;
    @(posedge clk);
    field_end <= 2'h0;
    repeat (14) @(posedge clk);
  endtask : run_field

  task automatic run_frame(input logic prog, input int len);
    run_field(2'h1, len);
    if (!prog)
      run_field(2'h2, len);
  endtask : run_frame

  // Service delay stays well short of the 14-cycle gap so prompt clears beat the next start
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      clr <= 4'h0;
      wait_cnt <= 0;
    end
    else
    begin
      clr <= (wait_cnt == 1) ? flags : 4'h0;
      if (wait_cnt != 0)
        wait_cnt <= wait_cnt - 1;
      else if (prompt && (|flags))
        wait_cnt <= 3;
    end
  end
endmodule : display_timing_model

`default_nettype wire

// ### testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import display_notify_pkg::*;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        en = 1'b1;
  logic        irq_en = 1'b1;
  logic        prompt = 1'b1;
  logic [3:0]  mode = SEL_NC_F1;
  logic [1:0]  fstart;
  logic [1:0]  fend;
  logic [3:0]  clr;
  logic [3:0]  flags;
  logic [1:0]  irqs;
  logic [1:0]  dma;
  logic [3:0]  m_flags;
  logic [1:0]  m_irqs;
  logic        m_dma;
  logic        ok, c, p, s, f, set1, set2, setp, na;
  int          fail_count = 0;
  int          tests_run = 0;
  int          cycles = 0;
  integer      seed = 32'h1D00A127;
  logic [31:0] r;
  // The six reserved codes are never programmed
  logic [3:0]  codes [10] = '{SEL_NC_F1, SEL_NC_F2, SEL_NC_BOTH, SEL_NC_FRAME, SEL_NC_PROG,
                              SEL_NC_SINGLE, SEL_C_F1, SEL_C_F2, SEL_C_FRAME, SEL_C_PROG};

  always #2.5 clk = ~clk;

  display_completion_notifier display_completion_notifier_i (
    .REF_CLK(clk), .NRST(nrst), .DISPLAY_ENABLE(en),
    .CONTINUOUS_DISPLAY_SEL(mode[3]), .PICTURE_SEL(mode[2]),
    .SECOND_FIELD_SELECT(mode[1]), .FIRST_FIELD_SELECT(mode[0]),
    .COMPLETE_IRQ_ENABLE(irq_en), .FIELD1_START(fstart[0]), .FIELD1_END(fend[0]),
    .FIELD2_START(fstart[1]), .FIELD2_END(fend[1]),
    .CLEAR_FIRST_FIELD_DONE(clr[0]), .CLEAR_SECOND_FIELD_DONE(clr[1]),
    .CLEAR_PICTURE_DONE(clr[2]), .CLEAR_COMPLETE(clr[3]),
    .FIRST_FIELD_DONE_FLAG(flags[0]), .SECOND_FIELD_DONE_FLAG(flags[1]),
    .PICTURE_DONE_FLAG(flags[2]), .DISPLAY_COMPLETE_STATUS(flags[3]),
    .DISPLAY_COMPLETE_IRQ(irqs[0]), .COMPLETION_NOT_ACKED_IRQ(irqs[1]),
    .DMA_REQUEST_ENABLE(dma[0]), .DATA_FROM_FIFO(dma[1]));

  display_timing_model display_timing_model_i (
    .clk(clk), .nrst(nrst), .prompt(prompt), .flags(flags),
    .field_start(fstart), .field_end(fend), .clr(clr));

  // ----------------------------------------------------------------
  // Reference model
  // ----------------------------------------------------------------
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      m_flags <= 4'h0;
      m_irqs <= 2'h0;
      m_dma <= 1'b0;
    end
    else
    begin
      ok = en && (mode inside {codes});
      {c, p, s, f} = mode;
      set1 = ok && !p && f && fend[0];
      set2 = ok && !p && s && fend[1];
      setp = ok && p && ((f && !s) ? fend[0] : fend[1]);
      na = ok && !c && ((!p && f && fstart[0] && m_flags[0])
           || (!p && s && fstart[1] && m_flags[1])
           || (p && s && fstart[0] && m_flags[2]) || (p && !s && setp && m_flags[2]));
      m_flags <= {set1 | set2 | setp, setp, set2, set1} | (m_flags & ~clr);
      m_irqs <= {na, (set1 | set2 | setp) && (!c || irq_en)};
      if (ok && ((fstart[0] && (f || (p && !s))) || (fstart[1] && (s || (p && !f)))))
        m_dma <= 1'b1;
      else if (|fend)
        m_dma <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Comparisons and verdict
  // ----------------------------------------------------------------
  task automatic cmp_flags(input logic [3:0] got, input logic [3:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t flags got %b exp %b", $time, got, exp);
    end
  endtask : cmp_flags

  task automatic cmp_irqs(input logic [1:0] got, input logic [1:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t irqs got %b exp %b", $time, got, exp);
    end
  endtask : cmp_irqs

  task automatic cmp_dma(input logic [1:0] got, input logic [1:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t dma got %b exp %b", $time, got, exp);
    end
  endtask : cmp_dma

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : print_verdict

  always @(negedge clk)
  begin
    if (nrst)
    begin
      cmp_flags(flags, m_flags);
      cmp_irqs(irqs, m_irqs);
      cmp_dma(dma, {m_dma, m_dma});
    end
  end

  // Hang guard: the whole sequence needs under 5000 cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 10000)
    begin
      fail_count++;
      print_verdict();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    // Enable passes a two-flop synchroniser, so let it settle before the first field
    repeat (3) @(posedge clk);
    for (int i = 0; i < 10; i++)
      for (int k = 0; k < 2; k++)
      begin
        r = $random(seed);
        mode <= codes[i];
        prompt <= (k == 0);
        irq_en <= r[0];
        repeat (3) display_timing_model_i.run_frame(codes[i][0] && !codes[i][1]
                                                     && (codes[i][2] || r[8]), 4 + r[6:4]);
        prompt <= 1'b1;
        repeat (10) @(posedge clk);
      end
    en <= 1'b0;
    mode <= SEL_NC_BOTH;
    repeat (3) @(posedge clk);
    display_timing_model_i.run_frame(1'b0, 6);
    print_verdict();
  end
endmodule : testbench

`default_nettype wire
